// >>> rtl/mcc_defines.svh
`ifndef MCC_DEFINES_SVH
`define MCC_DEFINES_SVH

// register byte address on the apb bus
`define MCC_CONFIG_OFFSET 16'he618
// value the register holds after reset: only the reserved bit 1 is set
`define MCC_CONFIG_RESET 16'h0002
// bits that store what software writes (bits 15:14 and the reset trigger excluded)
`define MCC_CONFIG_STORE_MASK 16'h3f7f

// single-bit field positions
`define MCC_BIT_PHASE_INT 0
`define MCC_BIT_RSVD_ONE 1
`define MCC_BIT_PULSE2_SEL 2
`define MCC_BIT_SWAP 3
`define MCC_BIT_VOLT_GND 4
`define MCC_BIT_CURR_GND 5
`define MCC_BIT_CAPTURE_EN 6
`define MCC_BIT_SOFT_RESET 7

// low bit of each two-bit voltage pairing field
`define MCC_FLD_PAIR_A_LSB 8
`define MCC_FLD_PAIR_B_LSB 10
`define MCC_FLD_PAIR_C_LSB 12

// neutral integrator enable position inside the third configuration register
`define MCC_THIRD_NEUTRAL_BIT 3

// number of phases
`define MCC_PHASES 3

`endif

// >>> rtl/mcc_pkg.sv
package mcc_pkg;

    // voltage pairing codes of one phase current
    typedef enum logic [1:0] {
        MCC_PAIR_OWN = 2'h0,
        MCC_PAIR_NEXT = 2'h1,
        MCC_PAIR_PREV = 2'h2,
        MCC_PAIR_RSVD = 2'h3
    } mcc_pair_type;

    // decoded view of the configuration register
    typedef struct packed {
        logic [1:0] spare_hi;
        mcc_pair_type phase_c_voltage_pairing;
        mcc_pair_type phase_b_voltage_pairing;
        mcc_pair_type phase_a_voltage_pairing;
        logic soft_reset_trigger;
        logic capture_port_enable;
        logic current_adc_ground;
        logic voltage_adc_ground;
        logic swap_channels;
        logic pulse2_pin_select;
        logic reserved_one;
        logic phase_integrator_enable;
    } mcc_cfg_type;

endpackage

// >>> rtl/mcc_pair_if.sv
`timescale 1ns/1ps

interface mcc_pair_if #(
    parameter int SAMPLE_WIDTH = 24
);
    // voltage samples indexed by phase a, b, c
    logic [2:0][SAMPLE_WIDTH-1:0] volt;
    // pairing code for each phase current
    logic [2:0][1:0] sel;
    // voltage chosen for each phase current
    logic [2:0][SAMPLE_WIDTH-1:0] paired;

    modport src (
        output volt,
        output sel,
        input paired
    );

    modport mux (
        input volt,
        input sel,
        output paired
    );
endinterface

// >>> rtl/mcc_pair_mux.sv
`timescale 1ns/1ps

module mcc_pair_mux
    import mcc_pkg::*;
(
    // pairing selects in, paired voltages out
    mcc_pair_if.mux pif
);

    // one selector per phase current: own, next or previous phase voltage
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_phase
            localparam int NEXT_IDX = (g + 1) % 3;
            localparam int PREV_IDX = (g + 2) % 3;
            // reserved code falls back to the own phase voltage
            assign pif.paired[g] = (pif.sel[g] == MCC_PAIR_NEXT) ? pif.volt[NEXT_IDX] :
                                   (pif.sel[g] == MCC_PAIR_PREV) ? pif.volt[PREV_IDX] :
                                   pif.volt[g];
        end
    endgenerate

endmodule

// >>> rtl/mcc_config_top.sv
// Functional notes
// - bit 0 holds the phase-current integrators disabled while 0 and enables them while 1.
// - the phase integrator enable never touches the neutral integrator, which follows bit 3 of the third register.
// - bit 2 puts the second energy pulse on the shared pin when 0 and the harmonic-ready flag when 1.
// - bit 3 exchanges the voltage and current channel outputs while set.
// - bit 4 makes the voltage converters deliver ground-level samples while set.
// - bit 5 makes the current converters deliver ground-level samples while set.
// - bit 6 enables the capture port and routes its clock to the third pin, else the third energy pulse.
// - writing 1 to bit 7 starts a software reset.
// - bits 9:8 pair phase a current with voltage a, b or c for codes 00, 01, 10.
// - bits 11:10 pair phase b current with voltage b, c or a for codes 00, 01, 10.
// - bits 13:12 pair phase c current with voltage c, a or b for codes 00, 01, 10.
// - code 11 in any pairing field acts as code 00.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "mcc_defines.svh"

module mcc_config_top
    import mcc_pkg::*;
#(
    parameter int SAMPLE_WIDTH = 24
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    // apb slave
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // third configuration register contents
    input wire logic [7:0] third_config_register,
    // converter samples, phase a in slot 0
    input wire logic sample_strobe,
    input wire logic [2:0][SAMPLE_WIDTH-1:0] voltage_adc,
    input wire logic [2:0][SAMPLE_WIDTH-1:0] current_adc,
    // channel registers and power path
    output logic channel_valid,
    output logic [2:0][SAMPLE_WIDTH-1:0] voltage_channel,
    output logic [2:0][SAMPLE_WIDTH-1:0] current_channel,
    output logic [2:0][SAMPLE_WIDTH-1:0] paired_voltage,
    // integrator controls
    output logic phase_integrator_enable,
    output logic neutral_integrator_enable,
    // shared pin sources
    input wire logic second_energy_pulse,
    input wire logic harmonic_ready,
    input wire logic third_energy_pulse,
    input wire logic capture_port_clock,
    // shared pins and capture port control
    output logic pulse2_pin,
    output logic pulse3_pin,
    output logic capture_port_enable,
    // software reset request to the rest of the device
    output logic soft_reset_pulse
);

    // stored register contents
    logic [15:0] channel_config;
    mcc_cfg_type cfg;
    logic [15:0] next_config;

    // apb decode
    logic addr_hit;
    logic access_phase;
    logic read_loaded;
    logic write_fire;
    logic [15:0] lane_mask;

    // sample path
    logic [2:0][SAMPLE_WIDTH-1:0] volt_eff;
    logic [2:0][SAMPLE_WIDTH-1:0] curr_eff;
    logic volt_valid;

    // pairing link to the selector
    mcc_pair_if #(.SAMPLE_WIDTH(SAMPLE_WIDTH)) pair_bus ();

    assign cfg = mcc_cfg_type'(channel_config);

    // address decode and phase tracking
    assign addr_hit = (paddr == `MCC_CONFIG_OFFSET);
    assign access_phase = psel & penable;
    assign write_fire = access_phase & pready & pwrite & addr_hit;

    // zero-wait answer once read data has been captured in the setup phase
    assign pready = clk_en & read_loaded;
    assign pslverr = access_phase & pready & ~addr_hit;

    // byte lanes 0 and 1 cover the sixteen register bits
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    // merge written lanes into the stored value; trigger bit and bits 15:14 never stored
    always_comb begin
        next_config = (channel_config & ~lane_mask) | (pwdata[15:0] & lane_mask);
        next_config = next_config & `MCC_CONFIG_STORE_MASK;
    end

    // read data is captured in the setup cycle so it comes from a flop
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            read_loaded <= 1'b0;
        end else if (clk_en) begin
            if (access_phase & read_loaded) begin
                read_loaded <= 1'b0;
            end else if (psel & ~penable) begin
                read_loaded <= 1'b1;
            end
        end
    end

    // read data register; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en) begin
            if (psel & ~penable) begin
                prdata <= addr_hit ? {16'h0000, channel_config} : 32'h0000_0000;
            end
        end
    end

    // configuration register; a reset trigger write restores defaults
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            channel_config <= `MCC_CONFIG_RESET;
        end else if (clk_en) begin
            if (write_fire) begin
                if (pstrb[0] & pwdata[`MCC_BIT_SOFT_RESET]) begin
                    channel_config <= `MCC_CONFIG_RESET;
                end else begin
                    channel_config <= next_config;
                end
            end
        end
    end

    // one-cycle software reset request
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            soft_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            soft_reset_pulse <= write_fire & pstrb[0] & pwdata[`MCC_BIT_SOFT_RESET];
        end
    end

    // integrator controls; the neutral one only follows the third register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            phase_integrator_enable <= 1'b0;
            neutral_integrator_enable <= 1'b0;
        end else if (clk_en) begin
            phase_integrator_enable <= cfg.phase_integrator_enable;
            neutral_integrator_enable <= third_config_register[`MCC_THIRD_NEUTRAL_BIT];
        end
    end

    // capture port enable follows its bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            capture_port_enable <= 1'b0;
        end else if (clk_en) begin
            capture_port_enable <= cfg.capture_port_enable;
        end
    end

    // shared pin routing from the stored selects
    assign pulse2_pin = cfg.pulse2_pin_select ? harmonic_ready : second_energy_pulse;
    assign pulse3_pin = cfg.capture_port_enable ? capture_port_clock : third_energy_pulse;

    // converter grounding applied ahead of the channel swap
    always_comb begin
        volt_eff = cfg.voltage_adc_ground ? '0 : voltage_adc;
        curr_eff = cfg.current_adc_ground ? '0 : current_adc;
    end

    // channel registers, exchanged while the swap bit is set
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            voltage_channel <= '0;
            current_channel <= '0;
        end else if (clk_en) begin
            if (sample_strobe) begin
                voltage_channel <= cfg.swap_channels ? curr_eff : volt_eff;
                current_channel <= cfg.swap_channels ? volt_eff : curr_eff;
            end
        end
    end

    // marks a fresh set of channel samples
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            volt_valid <= 1'b0;
        end else if (clk_en) begin
            volt_valid <= sample_strobe;
        end
    end

    // power path pairing driven from the channel voltages
    assign pair_bus.volt = voltage_channel;
    assign pair_bus.sel[0] = cfg.phase_a_voltage_pairing;
    assign pair_bus.sel[1] = cfg.phase_b_voltage_pairing;
    assign pair_bus.sel[2] = cfg.phase_c_voltage_pairing;

    mcc_pair_mux u_pair_mux (
        .pif(pair_bus.mux)
    );

    // paired voltages registered one cycle after the channel registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            paired_voltage <= '0;
            channel_valid <= 1'b0;
        end else if (clk_en) begin
            channel_valid <= volt_valid;
            if (volt_valid) begin
                paired_voltage <= pair_bus.paired;
            end
        end
    end

endmodule

// >>> testbench/mcc_config_assertions.sv
`timescale 1ns/1ps
`include "mcc_defines.svh"

module mcc_config_assertions (
    // watched top ports
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [15:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic [7:0] third_config_register,
    input wire logic sample_strobe,
    input wire logic channel_valid,
    input wire logic phase_integrator_enable,
    input wire logic neutral_integrator_enable,
    input wire logic second_energy_pulse,
    input wire logic harmonic_ready,
    input wire logic third_energy_pulse,
    input wire logic capture_port_clock,
    input wire logic pulse2_pin,
    input wire logic pulse3_pin,
    input wire logic capture_port_enable,
    input wire logic soft_reset_pulse
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    // completed write to the low byte lane of the register
    logic wr_lo;
    assign wr_lo = psel && penable && pready && pwrite && pstrb[0] && paddr == `MCC_CONFIG_OFFSET;

    int_en_a: assert property (
        wr_lo && !pwdata[7] |-> ##2 phase_integrator_enable == $past(pwdata[0], 2)) else $error("bad int enable");
    neutral_a: assert property (
        1'b1 |=> neutral_integrator_enable == $past(third_config_register[3])) else $error("bad neutral enable");
    pin2_sel_a: assert property (
        wr_lo && !pwdata[7] |=> pulse2_pin == ($past(pwdata[2]) ? harmonic_ready : second_energy_pulse))
        else $error("bad pin2 source");
    pin3_sel_a: assert property (
        wr_lo && !pwdata[7] |=> pulse3_pin == ($past(pwdata[6]) ? capture_port_clock : third_energy_pulse)
        ##1 capture_port_enable == $past(pwdata[6], 2)) else $error("bad pin3 source");
    soft_rst_a: assert property (
        wr_lo && pwdata[7] |=> ##[0:1] soft_reset_pulse ##1 !soft_reset_pulse) else $error("bad soft reset");
    rst_dflt_a: assert property (
        $fell(srst) |-> !capture_port_enable && !phase_integrator_enable && pulse2_pin == second_energy_pulse
        && pulse3_pin == third_energy_pulse) else $error("bad reset state");
    valid_a: assert property (
        sample_strobe |-> ##2 channel_valid) else $error("bad channel valid");
    ready_a: assert property (
        psel && !penable |=> pready) else $error("bad apb ready");
endmodule

bind mcc_config_top mcc_config_assertions i_chk (.*);

// >>> testbench/mcc_config_top_bench.sv
`timescale 1ns/1ps
`include "mcc_defines.svh"

module mcc_config_top_bench;
    // design inputs
    logic clk_sys = 0, srst = 1, clk_en = 1, psel = 0, penable = 0, pwrite = 0, sample_strobe = 0;
    logic second_energy_pulse = 0, harmonic_ready = 0, third_energy_pulse = 0, capture_port_clock = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [3:0] pstrb = 0;
    logic [7:0] third_config_register = 0;
    logic [2:0][23:0] voltage_adc = 0, current_adc = 0;
    // design outputs
    logic [31:0] prdata;
    logic pready, pslverr, channel_valid, phase_integrator_enable, neutral_integrator_enable;
    logic pulse2_pin, pulse3_pin, capture_port_enable, soft_reset_pulse;
    logic [2:0][23:0] voltage_channel, current_channel, paired_voltage;
    // bench state
    logic [31:0] rd_q;
    logic rd_err;
    logic [15:0] cfg;
    logic [2:0][23:0] ev, ec;
    int error_cnt = 0, compares = 0, cyc = 0, c;

    mcc_config_top i_dut (.*);

    // 20 mhz clock
    initial forever #25 clk_sys = ~clk_sys;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer: setup, then access held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [3:0] s);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= s;
        @(posedge clk_sys);
        penable <= 1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        // answer taken at the same edge that saw pready high
        rd_err = pslverr;
        rd_q = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask

    task final_report();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            final_report();
        end
    end

    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        srst <= 0;
        apb(0, `MCC_CONFIG_OFFSET, 0, 0);
        chk(rd_q, 32'h2);
        chk({capture_port_enable, phase_integrator_enable}, 0);
        $display("reset test done");
        apb(1, 16'he61c, 16'hffff, 4'hf);
        apb(0, 16'he61c, 0, 0);
        chk(rd_err, 1);
        chk(rd_q, 0);
        apb(0, `MCC_CONFIG_OFFSET, 0, 0);
        chk(rd_q, 32'h2);
        $display("unmapped test done");
        for (int i = 0; i < 8; i++) begin
            cfg = {2'h0, 2'(i + 2), 2'(i + 1), 2'(i), 1'b0, i[1], i[2:0], i[0], 1'b1, i[2]};
            {capture_port_clock, third_energy_pulse, harmonic_ready, second_energy_pulse} <= 4'(i) ^ 4'h6;
            third_config_register <= 8'(i * 8);
            for (int k = 0; k < 3; k++) begin
                voltage_adc[k] <= 24'(16 * k + i + 1);
                current_adc[k] <= 24'(4096 * (k + 1) + i);
            end
            apb(1, `MCC_CONFIG_OFFSET, cfg, 4'h3);
            apb(0, `MCC_CONFIG_OFFSET, 0, 0);
            chk(rd_q, {16'h0, cfg});
            sample_strobe <= 1;
            @(posedge clk_sys);
            sample_strobe <= 0;
            @(posedge clk_sys);
            @(negedge clk_sys);
            chk(channel_valid, 1);
            // grounding first, then the swap
            for (int k = 0; k < 3; k++) begin
                ev[k] = cfg[4] ? 24'h0 : voltage_adc[k];
                ec[k] = cfg[5] ? 24'h0 : current_adc[k];
            end
            if (cfg[3])
                {ev, ec} = {ec, ev};
            for (int k = 0; k < 3; k++) begin
                c = int'(cfg[8 + 2 * k +: 2]);
                chk(voltage_channel[k], ev[k]);
                chk(current_channel[k], ec[k]);
                chk(paired_voltage[k], ev[(k + (c == 3 ? 0 : c)) % 3]);
            end
            chk(phase_integrator_enable, cfg[0]);
            chk(neutral_integrator_enable, third_config_register[3]);
            chk(pulse2_pin, cfg[2] ? harmonic_ready : second_energy_pulse);
            chk(pulse3_pin, cfg[6] ? capture_port_clock : third_energy_pulse);
            chk(capture_port_enable, cfg[6]);
        end
        $display("field test done");
        apb(1, `MCC_CONFIG_OFFSET, 16'hffff, 4'h2);
        apb(0, `MCC_CONFIG_OFFSET, 0, 0);
        chk(rd_q, {16'h0, 8'h3f, cfg[7:0]});
        apb(1, `MCC_CONFIG_OFFSET, 16'h0081, 4'h1);
        apb(0, `MCC_CONFIG_OFFSET, 0, 0);
        chk(rd_q, 32'h2);
        chk(phase_integrator_enable, 0);
        $display("soft reset test done");
        final_report();
    end
endmodule
